// File: logic/adc_seq_map.vh
// adc_seq_map.vh: register offsets, field positions, reset values, timing counts
// assumes inclusion by the sequencer and prescaler files only
`ifndef ADC_SEQ_MAP_VH
`define ADC_SEQ_MAP_VH

// byte offsets of the register words
`define OFS_CONV_CTRL_STATUS 8'h00
`define OFS_IRQ_STATUS 8'h04
`define OFS_IRQ_MASK 8'h08
`define OFS_RESULT 8'h0c

// control word field positions
`define BIT_ENABLE 0
`define BIT_START 1
`define BIT_AUTO_TRIG 2
`define BIT_FREE_RUN 3
`define FLD_PRESCALE_LO 4
`define FLD_PRESCALE_HI 6
`define BIT_BUSY 7

// status and mask field position
`define BIT_DONE 0

// reset values
`define RST_PRESCALE 3'h0
`define RST_MASK 1'h0
`define RST_RESULT 10'h000

// conversion timing in converter clock cycles
`define CYC_NORMAL 5'h0d
`define CYC_FIRST 5'h19
`define SH_CYC_NORMAL 5'h01
`define SH_CYC_FIRST 5'h0d

// prescaler counter width, enough for the largest ratio of 256
`define PRE_W 8

// least cpu clock for the prescaler, in kHz
`define CPU_MIN_KHZ 100

`endif

// File: logic/adc_prescaler.v
// adc_prescaler.v: power-of-two divider making the converter clock
// assumes one cpu clock domain; enable and clear come from the same clock
`timescale 1ns/10ps
`default_nettype none
`include "adc_seq_map.vh"

module adc_prescaler #(
	parameter W = `PRE_W
) (
	input wire clk,
	input wire reset,
	input wire enable,
	input wire clear,
	input wire [2:0] sel,
	output reg convClk_r,
	output wire riseTick,
	output wire fallTick
);

	reg [W-1:0] cnt_r;
	wire [W-1:0] mask;
	wire [W-1:0] half;

	// ratio is 2 << sel, so code 0 divides by 2 and code 7 by 256
	assign mask = ({{(W-2){1'b0}}, 2'b10} << sel) - {{(W-1){1'b0}}, 1'b1};
	assign half = mask >> 1;
	// ticks mark the cpu edge on which the converter clock will toggle
	assign riseTick = enable & ~clear & ((cnt_r & mask) == half);
	assign fallTick = enable & ~clear & ((cnt_r & mask) == mask);

	// held at zero while disabled or on a trigger clear
	always @(posedge clk) begin
		if (reset || !enable || clear) begin
			cnt_r <= {W{1'b0}};
			convClk_r <= 1'b0;
		end else begin
			cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
			if (riseTick)
				convClk_r <= 1'b1;
			else if (fallTick)
				convClk_r <= 1'b0;
		end
	end

endmodule // adc_prescaler

`default_nettype wire

// File: logic/adc_conversion_sequencer.v
// adc_conversion_sequencer.v: conversion sequencer with ahb-lite register slave
// assumes the analog core presents its result on convResult, stable at completion
//
// Chosen here: the address map and the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "adc_seq_map.vh"

module adc_conversion_sequencer #(
	parameter RES_W = 10
) (
	input wire clk,
	input wire reset,
	// ahb-lite slave
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire hreadyout,
	output wire hresp,
	output reg [31:0] hrdata,
	// trigger source pin, analog core and interrupt
	input wire trigIn,
	input wire [RES_W-1:0] convResult,
	output wire convClk,
	output reg sampleHold_r,
	output reg convActive_r,
	output reg convDone_r,
	output reg irq_r
);

	localparam ST_IDLE = 2'b00;
	localparam ST_WAIT = 2'b01;
	localparam ST_CONV = 2'b10;

	// control, status, mask and result register fields
	reg enable_r;
	reg startBit_r;
	reg autoTrig_r;
	reg freeRun_r;
	reg [2:0] prescale_r;
	reg irqMask_r;
	reg doneFlag_r;
	reg [RES_W-1:0] result_r;

	// bus address phase capture
	reg wrPend_r;
	reg [7:0] wrAddr_r;

	// sequencer state
	reg [1:0] state_r;
	reg [1:0] state_nxt;
	reg [4:0] cycCnt_r;
	reg firstConv_r;

	// trigger synchroniser and delay
	reg trigSync1_r;
	reg trigSync2_r;
	reg trigSync3_r;
	reg trigEvent_r;

	wire riseTick;
	wire fallTick;
	wire addrPhase;
	reg wrCtrl;
	reg wrStatus;
	reg wrMask;
	reg [31:0] rdMux;
	wire swStart;
	wire trigStart;
	wire [4:0] convLen;
	wire [4:0] shCyc;
	wire complete;
	wire shNow;
	wire busy;
	wire clearDone;
	wire abortConv;
	wire finishConv;
	wire restartConv;
	wire [4:0] lastCyc;
	wire trigRise;

	// zero wait states, always okay
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign addrPhase = hsel & hready & htrans[1];

	// write strobes in the data phase, one register per captured address
	always @* begin
		wrCtrl = 1'b0;
		wrStatus = 1'b0;
		wrMask = 1'b0;
		if (wrPend_r) begin
			if (wrAddr_r == `OFS_CONV_CTRL_STATUS) begin
				wrCtrl = 1'b1;
			end else if (wrAddr_r == `OFS_IRQ_STATUS) begin
				wrStatus = 1'b1;
			end else if (wrAddr_r == `OFS_IRQ_MASK) begin
				wrMask = 1'b1;
			end
			// the result word is read-only, other offsets are ignored
		end
	end

	// capture address and direction for the following data phase
	always @(posedge clk) begin
		if (reset) begin
			wrPend_r <= 1'b0;
			wrAddr_r <= 8'h00;
		end else begin
			wrPend_r <= addrPhase & hwrite;
			if (addrPhase)
				wrAddr_r <= haddr[7:0];
		end
	end

	// read mux; fields are sampled at the address phase
	always @* begin
		rdMux = 32'h00000000;
		if (haddr[7:0] == `OFS_CONV_CTRL_STATUS) begin
			rdMux[`BIT_ENABLE] = enable_r;
			rdMux[`BIT_START] = startBit_r | busy;
			rdMux[`BIT_AUTO_TRIG] = autoTrig_r;
			rdMux[`BIT_FREE_RUN] = freeRun_r;
			rdMux[`FLD_PRESCALE_HI:`FLD_PRESCALE_LO] = prescale_r;
			rdMux[`BIT_BUSY] = busy;
		end else if (haddr[7:0] == `OFS_IRQ_STATUS) begin
			rdMux[`BIT_DONE] = doneFlag_r;
		end else if (haddr[7:0] == `OFS_IRQ_MASK) begin
			rdMux[`BIT_DONE] = irqMask_r;
		end else if (haddr[7:0] == `OFS_RESULT) begin
			rdMux[RES_W-1:0] = result_r;
		end
		// unmapped offsets fall through as zero
	end

	// read data registered at the address phase so hrdata is a flop output
	always @(posedge clk) begin
		if (reset) begin
			hrdata <= 32'h00000000;
		end else if (addrPhase && !hwrite) begin
			hrdata <= rdMux;
		end
	end

	// converter clock divider, cleared on each accepted trigger start
	adc_prescaler #(
		.W(`PRE_W)
	) u_prescaler (
		.clk(clk),
		.reset(reset),
		.enable(enable_r),
		.clear(trigStart),
		.sel(prescale_r),
		.convClk_r(convClk),
		.riseTick(riseTick),
		.fallTick(fallTick)
	);

	// rising edge seen after the two synchroniser flops
	assign trigRise = trigSync2_r & ~trigSync3_r;

	// trigger pin: two flops, then edge detect and one delay flop,
	// three cpu cycles from pin edge to prescaler clear
	always @(posedge clk) begin
		if (reset) begin
			trigSync1_r <= 1'b0;
			trigSync2_r <= 1'b0;
			trigSync3_r <= 1'b0;
			trigEvent_r <= 1'b0;
		end else begin
			trigSync1_r <= trigIn;
			trigSync2_r <= trigSync1_r;
			trigSync3_r <= trigSync2_r;
			trigEvent_r <= trigRise;
		end
	end

	// start sources; a software start is honoured even with auto trigger on
	assign swStart = wrCtrl & hwdata[`BIT_START] & hwdata[`BIT_ENABLE];
	// triggers landing mid-conversion are dropped, as the core is occupied
	assign trigStart = trigEvent_r & autoTrig_r & enable_r & (state_r == ST_IDLE);

	// conversion length and sample-hold point depend on first conversion
	assign convLen = firstConv_r ? `CYC_FIRST : `CYC_NORMAL;
	assign shCyc = firstConv_r ? `SH_CYC_FIRST : `SH_CYC_NORMAL;
	assign lastCyc = convLen - 5'h01;
	assign complete = (state_r == ST_CONV) & riseTick & (cycCnt_r == lastCyc);
	// falling edge after rise n is n plus one half cycle from the start
	assign shNow = (state_r == ST_CONV) & fallTick & (cycCnt_r == shCyc);
	assign busy = (state_r != ST_IDLE);

	// abort only while enable stays low; the enabling write may carry the start
	assign abortConv = !enable_r && !swStart;
	// single mode ends at completion, free running chains the next conversion
	assign finishConv = complete & ~freeRun_r;
	assign restartConv = complete & freeRun_r;

	// sequencer next state
	always @* begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (swStart || trigStart)
					state_nxt = ST_WAIT;
			end
			ST_WAIT: begin
				if (riseTick)
					state_nxt = ST_CONV;
			end
			ST_CONV: begin
				if (finishConv)
					state_nxt = ST_IDLE;
				else if (restartConv)
					state_nxt = ST_CONV;
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
		// disabling the converter aborts any conversion
		if (abortConv)
			state_nxt = ST_IDLE;
	end

	// sequencer state and cycle count in converter clock rises
	always @(posedge clk) begin
		if (reset) begin
			state_r <= ST_IDLE;
			cycCnt_r <= 5'h00;
		end else begin
			state_r <= state_nxt;
			if (state_r == ST_WAIT && riseTick)
				cycCnt_r <= 5'h00;
			else if (complete)
				cycCnt_r <= 5'h00;
			else if (state_r == ST_CONV && riseTick)
				cycCnt_r <= cycCnt_r + 5'h01;
		end
	end

	// first-conversion marker: armed while disabled, dropped at first completion
	always @(posedge clk) begin
		if (reset)
			firstConv_r <= 1'b1;
		else if (!enable_r)
			firstConv_r <= 1'b1;
		else if (complete)
			firstConv_r <= 1'b0;
	end

	// control register and start bit
	always @(posedge clk) begin
		if (reset) begin
			enable_r <= 1'b0;
			startBit_r <= 1'b0;
			autoTrig_r <= 1'b0;
			freeRun_r <= 1'b0;
			prescale_r <= `RST_PRESCALE;
		end else begin
			if (wrCtrl) begin
				enable_r <= hwdata[`BIT_ENABLE];
				autoTrig_r <= hwdata[`BIT_AUTO_TRIG];
				freeRun_r <= hwdata[`BIT_FREE_RUN];
				prescale_r <= hwdata[`FLD_PRESCALE_HI:`FLD_PRESCALE_LO];
			end
			// a start request wins over the completion clear
			if (swStart)
				startBit_r <= 1'b1;
			else if (trigStart)
				startBit_r <= 1'b1;
			else if (restartConv)
				startBit_r <= 1'b1;
			else if (finishConv)
				startBit_r <= 1'b0;
			else if (abortConv)
				startBit_r <= 1'b0;
		end
	end

	// result register, loaded only at completion so software reads a whole word
	always @(posedge clk) begin
		if (reset)
			result_r <= `RST_RESULT;
		else if (complete)
			result_r <= convResult;
	end

	// done flag; set wins over the write-one clear
	assign clearDone = wrStatus & hwdata[`BIT_DONE];
	always @(posedge clk) begin
		if (reset)
			doneFlag_r <= 1'b0;
		else if (complete)
			doneFlag_r <= 1'b1;
		else if (clearDone)
			doneFlag_r <= 1'b0;
	end

	// interrupt mask
	always @(posedge clk) begin
		if (reset)
			irqMask_r <= `RST_MASK;
		else if (wrMask)
			irqMask_r <= hwdata[`BIT_DONE];
	end

	// status outputs toward the analog core, all registered
	always @(posedge clk) begin
		if (reset) begin
			sampleHold_r <= 1'b0;
			convActive_r <= 1'b0;
			convDone_r <= 1'b0;
		end else begin
			sampleHold_r <= shNow;
			convActive_r <= (state_nxt == ST_CONV);
			convDone_r <= complete;
		end
	end

	// level interrupt one cycle behind the flag, so no glitch from the gate
	always @(posedge clk) begin
		if (reset)
			irq_r <= 1'b0;
		else
			irq_r <= doneFlag_r & irqMask_r;
	end

endmodule // adc_conversion_sequencer

`default_nettype wire

// File: test/adc_seq_chk_sva.sv
// adc_seq_chk_sva.sv: port-level checks for the conversion sequencer
// assumes the bind below attaches it to every sequencer instance
`timescale 1ns/10ps
`default_nettype none
module adc_seq_chk (
	input wire clk,
	input wire reset,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [31:0] hwdata,
	input wire hready,
	input wire hreadyout,
	input wire hresp,
	input wire [31:0] hrdata,
	input wire sampleHold_r,
	input wire convActive_r,
	input wire convDone_r
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// address phases seen by the slave
	sequence s_rd;
		hsel && hready && htrans[1] && !hwrite;
	endsequence
	sequence s_wr_start;
		hsel && hready && htrans[1] && hwrite && haddr[7:0] == 8'h00 ##1 hwdata[1:0] == 2'h3;
	endsequence
	property p_zero_wait; hreadyout && !hresp; endproperty
	property p_unmapped; s_rd ##0 haddr[7:0] > 8'h0c |=> hrdata == 32'h0; endproperty
	property p_busy_read; s_rd ##0 haddr[7:0] == 8'h00 && convActive_r |=> hrdata[1]; endproperty
	// worst case waits a full /256 converter period for the first rise
	property p_start; s_wr_start |-> ##[1:600] convActive_r; endproperty
	property p_done_pulse; convDone_r |=> !convDone_r; endproperty
	property p_sh_pulse; sampleHold_r |=> !sampleHold_r; endproperty
	property p_done_in_conv; convDone_r |-> $past(convActive_r); endproperty
	property p_sh_in_conv; sampleHold_r |-> $past(convActive_r); endproperty
	a_zero_wait: assert property (p_zero_wait) else $error("slave stalled or errored");
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	a_busy_read: assert property (p_busy_read) else $error("start bit low in conversion");
	a_start: assert property (p_start) else $error("start write began nothing");
	a_done_pulse: assert property (p_done_pulse) else $error("done pulse too long");
	a_sh_pulse: assert property (p_sh_pulse) else $error("hold pulse too long");
	a_done_in_conv: assert property (p_done_in_conv) else $error("done outside conversion");
	a_sh_in_conv: assert property (p_sh_in_conv) else $error("hold outside conversion");
endmodule // adc_seq_chk
bind adc_conversion_sequencer adc_seq_chk chk (.clk(clk), .reset(reset), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
	.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sampleHold_r(sampleHold_r),
	.convActive_r(convActive_r), .convDone_r(convDone_r));
`default_nettype wire

// File: test/adc_conversion_sequencer_test.sv
// adc_conversion_sequencer_test.sv: register-level bench of the sequencer
// assumes the design files compile first; the bench acts as bus master
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin numChecks++; if ((got) !== (ex)) begin miscompares++; \
	$display("[ERR] %s exp %0h got %0h", nm, ex, got); end end
module adc_conversion_sequencer_test;
	logic clk, reset, hsel, hwrite, trigIn, c0, c1;
	logic [31:0] haddr, hwdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [9:0] convResult;
	wire hreadyout, hresp, convClk, sampleHold_r, convActive_r, convDone_r, irq_r;
	wire [31:0] hrdata;
	int miscompares, numChecks, tA, sA, tB, sB, tC, sC, d0, d1;

	adc_conversion_sequencer dut (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .trigIn(trigIn),
		.convResult(convResult), .convClk(convClk), .sampleHold_r(sampleHold_r),
		.convActive_r(convActive_r), .convDone_r(convDone_r), .irq_r(irq_r));

	// 20 MHz cpu clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// one single word transfer, waits on hready in both phases
	task ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask

	// cycles from conversion start (or trigger) to hold pulse and to done
	task meas(input bit trig, output int tDone, output int tSh);
		int n;
		n = 0;
		tSh = -1;
		if (trig) begin
			@(posedge clk);
			trigIn <= 1'b1;
		end
		while (!trig && convActive_r !== 1'b1) @(negedge clk);
		do begin
			@(negedge clk);
			n++;
			if (sampleHold_r === 1'b1) tSh = n;
		end while (convDone_r !== 1'b1);
		tDone = n;
		@(posedge clk);
		trigIn <= 1'b0;
	endtask

	task tdone(input string s);
		$display("test %s done", s);
	endtask

	task final_report;
		$display("checks %0d miscompares %0d", numChecks, miscompares);
		if (miscompares == 0 && numChecks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// cut a hang short, well beyond the expected run
	initial begin
		#2000000;
		miscompares++;
		final_report;
	end

	initial begin
		reset = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		trigIn = 1'b0;
		convResult = 10'h2a5;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		// reset values and an unmapped place
		ahb(0, 8'h00, 0, rd); `CHK("ctrl rst", 32'h0, rd)
		ahb(0, 8'h08, 0, rd); `CHK("mask rst", 32'h0, rd)
		ahb(1, 8'h10, 32'hffffffff, rd);
		ahb(0, 8'h10, 0, rd); `CHK("unmapped", 32'h0, rd)
		tdone("reset");
		// first then normal conversions at /2, then /4
		ahb(1, 8'h00, 32'h03, rd); meas(0, tA, sA);
		ahb(0, 8'h0c, 0, rd); `CHK("result", 32'h2a5, rd)
		ahb(0, 8'h04, 0, rd); `CHK("done flag", 32'h1, rd)
		ahb(0, 8'h00, 0, rd); `CHK("start clr", 1'b0, rd[1])
		ahb(1, 8'h00, 32'h07, rd); meas(0, tB, sB);
		`CHK("first len", 24, tA - tB)
		`CHK("first sh", 24, sA - sB)
		`CHK("normal len", 1'b1, tB >= 25 && tB <= 27)
		convResult <= 10'h15a;
		ahb(1, 8'h00, 32'h17, rd); meas(0, tC, sC);
		`CHK("div ratio", 26, tC - tB)
		`CHK("normal sh", 3, sC - sB)
		ahb(0, 8'h0c, 0, rd); `CHK("result2", 32'h15a, rd)
		tdone("single");
		// triggered starts at three prescale codes
		ahb(1, 8'h00, 32'h05, rd); meas(1, tA, d0);
		ahb(1, 8'h00, 32'h15, rd); meas(1, tA, d1);
		`CHK("trig delay", 1'b1, d0 >= 7 && d0 <= 10)
		`CHK("trig fixed", 4, d1 - d0)
		ahb(1, 8'h00, 32'h75, rd);
		trigIn <= 1'b1;
		repeat (20) @(posedge clk);
		trigIn <= 1'b0;
		ahb(0, 8'h00, 0, rd); `CHK("busy start", 1'b1, rd[1])
		ahb(1, 8'h00, 32'h00, rd);
		tdone("trigger");
		// interrupt raised by mask, dropped by clear
		ahb(1, 8'h08, 32'h1, rd);
		repeat (2) @(negedge clk); `CHK("irq on", 1'b1, irq_r)
		`CHK("clk held", 1'b0, convClk)
		ahb(1, 8'h04, 32'h1, rd);
		repeat (2) @(negedge clk); `CHK("irq clr", 1'b0, irq_r)
		ahb(1, 8'h08, 32'h0, rd);
		// free running restarts with the start bit held
		ahb(1, 8'h00, 32'h0b, rd); meas(0, tA, sA); meas(0, tB, sB);
		`CHK("free len", 26, tB)
		ahb(0, 8'h00, 0, rd); `CHK("free start", 1'b1, rd[1])
		@(negedge clk) c0 = convClk;
		@(negedge clk) c1 = convClk;
		`CHK("conv clk", 1'b1, c0 ^ c1)
		`CHK("irq masked", 1'b0, irq_r)
		tdone("free run");
		final_report;
	end
endmodule // adc_conversion_sequencer_test
`default_nettype wire
